/* File: common/seq_pkg.sv */
// Constants and carriers for the converter channel sequencer.
// Assumes one clock domain; serial pins arrive asynchronous to it.
package seq_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_INPUTS = 8;
  localparam int CHAN_W = 3;
  localparam int HEAD_W = 16;
  localparam int FRAME_MAX = 24;
  localparam int BITCNT_W = 5;
  localparam int SYNC_DEPTH = 3;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // Frame field positions
  // ****************************************
  localparam int SEL_BIT = 15;
  localparam int CODE_HI = 14;
  localparam int CODE_LO = 11;
  localparam int CODE_BAD_BIT = 3;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] STYLE_MANUAL = 2'h0;
  localparam logic [1:0] STYLE_OTF = 2'h1;
  localparam logic [1:0] STYLE_AUTO = 2'h2;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [2:0] CHAN_ZERO = 3'h0;
  localparam logic [15:0] HEAD_NOP = 16'h0000;
  localparam logic [4:0] BITCNT_ZERO = 5'h00;
  localparam logic [4:0] BITCNT_ONE = 5'h01;
  localparam logic [4:0] BITCNT_HEAD = 5'h10;
  localparam logic [4:0] BITCNT_MAX = 5'h18;

  typedef enum {SCAN_IDLE, SCAN_RUN} scan_state_e;

  typedef struct packed {
    logic [1:0] style;
    logic otf_en;
    logic rpt_en;
    logic [7:0] mask;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{STYLE_MANUAL, 1'b0, 1'b0, MASK_RESET};

  typedef struct packed {
    logic [2:0] chan;
    logic cmd_valid;
    logic [4:0] bits;
    logic [15:0] head;
  } conv_rec_s;

endpackage

/* File: hdl/seq_fifo.sv */
// Small synchronous FIFO with a registered output stage.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module seq_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Room available
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Output word held
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data // Output word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic push, load;

  assign in_ready = (count_reg != CNT_FULL);
  assign push = in_valid && in_ready;
  assign load = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    out_valid_next = out_valid_reg;
    out_data_next = out_data_reg;
    if (out_valid_reg && out_ready) begin
      out_valid_next = 1'b0;
    end
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (load) begin
      out_data_next = mem_reg[rd_ptr_reg];
      out_valid_next = 1'b1;
      rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
    end
    count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  always_ff @(posedge clk) begin
    mem_reg <= mem_next;
  end

endmodule

/* File: hdl/adc_mux_channel_sequencer.sv */
// Channel sequencer: serial frame capture, fly-by and auto-scan selection.
// Assumes serial pins are asynchronous and much slower than clk.
`timescale 1ns/10ps

// Notes on behaviour
// - All-zero frame keeps the current input unless a scan is running
// - Fly-by channel change applies to the same frame
// - Style value 01b selects fly-by switching
// - Leading one plus four bits pick input
// - Leading zero frame decoded as normal command
// - Bad code sets error, picks input zero
// - Sixteen-bit frames allowed in fly-by style
// - Style 10b scans enabled inputs ascending
// - Eight-bit enable mask, all enabled after reset
// - Launch bit starts; advance each frame end
// - Busy pin high until last frame, then input zero
// - After finished scan, frames convert input zero
// - Repeat bit restarts from first enabled input
// - Cancel bit stops scan, selects input zero
// - Reset gives manual style and input zero
// - Frame command handled at chip-select rising edge
module adc_mux_channel_sequencer #(
  parameter int NUM_CH = seq_pkg::NUM_INPUTS,
  parameter int REC_DEPTH = seq_pkg::FIFO_DEPTH
) (
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // Sync reset, active high
  input wire logic sclk_pin, // Serial clock pin
  input wire logic cs_n_pin, // Chip select pin, low active
  input wire logic sdi_pin, // Serial data in pin
  input wire logic cfg_wr, // Config write strobe
  input wire seq_pkg::cfg_s cfg_in, // Config write value
  input wire logic scan_launch_bit, // Start auto scan pulse
  input wire logic scan_cancel_bit, // Abort auto scan pulse
  input wire logic flag_clear, // Clears error and drop flags
  output seq_pkg::cfg_s cfg_out, // Config readback
  output logic [seq_pkg::CHAN_W-1:0] mux_sel, // Active input
  output logic conv_start, // Conversion start pulse
  output logic [seq_pkg::CHAN_W-1:0] conv_chan, // Input being converted
  output logic otf_error, // Bad fly-by code seen
  output logic rec_drop, // Record lost, queue full
  output logic scan_busy_pin_o, // Busy pin output level
  output logic scan_busy_pin_oe, // Busy pin drive enable
  output logic rec_valid, // Frame record available
  input wire logic rec_ready, // Frame record taken
  output seq_pkg::conv_rec_s rec_data // Frame record
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [seq_pkg::SYNC_DEPTH-1:0] sclk_sync_reg, sclk_sync_next;
  logic [seq_pkg::SYNC_DEPTH-1:0] cs_sync_reg, cs_sync_next;
  logic [seq_pkg::SYNC_DEPTH-1:0] sdi_sync_reg, sdi_sync_next;
  logic sclk_rise, cs_rise, cs_fall, cs_low, sdi_bit;

  always_comb begin
    sclk_sync_next = {sclk_sync_reg[seq_pkg::SYNC_DEPTH-2:0], sclk_pin};
    cs_sync_next = {cs_sync_reg[seq_pkg::SYNC_DEPTH-2:0], cs_n_pin};
    sdi_sync_next = {sdi_sync_reg[seq_pkg::SYNC_DEPTH-2:0], sdi_pin};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_sync_reg <= '0;
      cs_sync_reg <= '1;
      sdi_sync_reg <= '0;
    end else begin
      sclk_sync_reg <= sclk_sync_next;
      cs_sync_reg <= cs_sync_next;
      sdi_sync_reg <= sdi_sync_next;
    end
  end

  // Stages two and three judge each change
  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign cs_rise = cs_sync_reg[1] && !cs_sync_reg[2];
  assign cs_fall = !cs_sync_reg[1] && cs_sync_reg[2];
  assign cs_low = !cs_sync_reg[1] && !cs_sync_reg[2];
  assign sdi_bit = sdi_sync_reg[1];

  // ****************************************
  // Frame capture
  // ****************************************
  logic [seq_pkg::HEAD_W-1:0] head_reg, head_next;
  logic [seq_pkg::BITCNT_W-1:0] bits_reg, bits_next;

  always_comb begin
    head_next = head_reg;
    bits_next = bits_reg;
    if (cs_fall) begin
      head_next = seq_pkg::HEAD_NOP;
      bits_next = seq_pkg::BITCNT_ZERO;
    end else if (cs_low && sclk_rise) begin
      // First sixteen bits hold the command head; 24-bit frames also fit
      if (bits_reg < seq_pkg::BITCNT_HEAD) begin
        head_next = {head_reg[seq_pkg::HEAD_W-2:0], sdi_bit};
      end
      if (bits_reg != seq_pkg::BITCNT_MAX) begin
        bits_next = bits_reg + seq_pkg::BITCNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head_reg <= seq_pkg::HEAD_NOP;
      bits_reg <= seq_pkg::BITCNT_ZERO;
    end else begin
      head_reg <= head_next;
      bits_reg <= bits_next;
    end
  end

  // ****************************************
  // Configuration
  // ****************************************
  seq_pkg::cfg_s cfg_reg, cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr) begin
      cfg_next = cfg_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= seq_pkg::CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ****************************************
  // Mask search helpers
  // ****************************************
  function automatic logic [seq_pkg::CHAN_W-1:0] first_enabled(
    input logic [NUM_CH-1:0] mask
  );
    logic [seq_pkg::CHAN_W-1:0] pick;
    pick = seq_pkg::CHAN_ZERO;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        pick = seq_pkg::CHAN_W'(i);
      end
    end
    return pick;
  endfunction

  // Bit 3 of result flags that a higher enabled input exists
  function automatic logic [seq_pkg::CHAN_W:0] next_enabled(
    input logic [NUM_CH-1:0] mask,
    input logic [seq_pkg::CHAN_W-1:0] cur
  );
    logic [seq_pkg::CHAN_W:0] pick;
    pick = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && (i > int'(cur))) begin
        pick = {1'b1, seq_pkg::CHAN_W'(i)};
      end
    end
    return pick;
  endfunction

  // ****************************************
  // Channel selection and scan control
  // ****************************************
  seq_pkg::scan_state_e state_reg, state_next;
  logic [seq_pkg::CHAN_W-1:0] chan_reg, chan_next;
  logic [seq_pkg::CHAN_W-1:0] conv_chan_reg, conv_chan_next;
  logic conv_start_reg, conv_start_next;
  logic busy_reg, busy_next;
  logic err_reg, err_next;
  logic drop_reg, drop_next;
  logic err_set, cmd_valid, fly_sel;
  logic [3:0] fly_code;
  logic [seq_pkg::CHAN_W:0] adv;
  logic fifo_in_ready;
  seq_pkg::conv_rec_s rec_in;

  assign fly_code = head_reg[seq_pkg::CODE_HI:seq_pkg::CODE_LO];
  assign fly_sel = (cfg_reg.style == seq_pkg::STYLE_OTF) && cfg_reg.otf_en
                   && head_reg[seq_pkg::SEL_BIT];
  assign adv = next_enabled(cfg_reg.mask, chan_reg);

  always_comb begin
    state_next = state_reg;
    chan_next = chan_reg;
    conv_chan_next = conv_chan_reg;
    conv_start_next = 1'b0;
    err_set = 1'b0;
    cmd_valid = 1'b0;
    if (cs_rise) begin
      conv_start_next = 1'b1;
      // Conversion uses the input chosen before this frame; a fly-by frame converts its new input
      conv_chan_next = chan_reg;
      if (fly_sel) begin
        if (fly_code[seq_pkg::CODE_BAD_BIT]) begin
          err_set = 1'b1;
          chan_next = seq_pkg::CHAN_ZERO;
        end else begin
          chan_next = fly_code[seq_pkg::CHAN_W-1:0];
        end
        conv_chan_next = chan_next;
      end else begin
        // A NOP head is no command and leaves the input alone
        cmd_valid = (head_reg != seq_pkg::HEAD_NOP);
      end
      if (state_reg == seq_pkg::SCAN_RUN) begin
        if (adv[seq_pkg::CHAN_W]) begin
          chan_next = adv[seq_pkg::CHAN_W-1:0];
        end else if (cfg_reg.rpt_en) begin
          chan_next = first_enabled(cfg_reg.mask);
        end else begin
          state_next = seq_pkg::SCAN_IDLE;
          chan_next = seq_pkg::CHAN_ZERO;
        end
      end
    end
    if (cfg_reg.style != seq_pkg::STYLE_AUTO && state_reg == seq_pkg::SCAN_RUN) begin
      state_next = seq_pkg::SCAN_IDLE;
      chan_next = seq_pkg::CHAN_ZERO;
    end
    if (scan_cancel_bit) begin
      if (state_reg == seq_pkg::SCAN_RUN) begin
        chan_next = seq_pkg::CHAN_ZERO;
      end
      state_next = seq_pkg::SCAN_IDLE;
    end else if (scan_launch_bit && cfg_reg.style == seq_pkg::STYLE_AUTO
                 && cfg_reg.mask != seq_pkg::MASK_NONE) begin
      state_next = seq_pkg::SCAN_RUN;
      chan_next = first_enabled(cfg_reg.mask);
    end
    busy_next = (state_next == seq_pkg::SCAN_RUN);
    err_next = err_set || (err_reg && !flag_clear);
    drop_next = (cs_rise && !fifo_in_ready) || (drop_reg && !flag_clear);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= seq_pkg::SCAN_IDLE;
      chan_reg <= seq_pkg::CHAN_ZERO;
      conv_chan_reg <= seq_pkg::CHAN_ZERO;
      conv_start_reg <= 1'b0;
      busy_reg <= 1'b0;
      err_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      conv_chan_reg <= conv_chan_next;
      conv_start_reg <= conv_start_next;
      busy_reg <= busy_next;
      err_reg <= err_next;
      drop_reg <= drop_next;
    end
  end

  // ****************************************
  // Frame record queue
  // ****************************************
  always_comb begin
    rec_in.chan = conv_chan_next;
    rec_in.cmd_valid = cmd_valid;
    rec_in.bits = bits_reg;
    rec_in.head = head_reg;
  end

  seq_fifo #(
    .WIDTH($bits(seq_pkg::conv_rec_s)),
    .DEPTH(REC_DEPTH)
  ) u_rec_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cs_rise),
    .in_ready(fifo_in_ready),
    .in_data(rec_in),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign cfg_out = cfg_reg;
  assign mux_sel = chan_reg;
  assign conv_start = conv_start_reg;
  assign conv_chan = conv_chan_reg;
  assign otf_error = err_reg;
  assign rec_drop = drop_reg;
  assign scan_busy_pin_o = busy_reg;
  assign scan_busy_pin_oe = busy_reg;

endmodule

/* File: test/seq_properties.sv */
// Port assertions for the channel sequencer.
// Assumes it is bound into the sequencer top module.
`timescale 1ns/10ps
module seq_properties #(
  parameter int NUM_CH = 8,
  parameter int REC_DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic cfg_wr, // Config strobe
  input wire logic scan_launch_bit, // Scan start
  input wire logic scan_cancel_bit, // Scan abort
  input wire seq_pkg::cfg_s cfg_out, // Config
  input wire logic [seq_pkg::CHAN_W-1:0] mux_sel, // Input
  input wire logic conv_start, // Conv pulse
  input wire logic [seq_pkg::CHAN_W-1:0] conv_chan, // Conv input
  input wire logic otf_error, // Error flag
  input wire logic scan_busy_pin_o, // Busy level
  input wire logic scan_busy_pin_oe // Busy enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] low_ch;
  // Lowest enabled input of the mask
  always_comb begin
    low_ch = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (cfg_out.mask[i]) begin
        low_ch = 3'(i);
      end
    end
  end
  reset_vals_a: assert property ($fell(rst) |->
    cfg_out == seq_pkg::CFG_RESET && mux_sel == 3'h0 && !scan_busy_pin_oe)
    else $error("reset values wrong");
  busy_level_a: assert property (scan_busy_pin_oe |-> scan_busy_pin_o)
    else $error("busy pin driven low");
  launch_scan_a: assert property (scan_launch_bit && !scan_cancel_bit &&
    !cfg_wr && cfg_out.style == seq_pkg::STYLE_AUTO && cfg_out.mask != 8'h00
    |=> scan_busy_pin_oe && mux_sel == $past(low_ch))
    else $error("scan start wrong");
  cancel_scan_a: assert property (scan_cancel_bit && scan_busy_pin_oe |=>
    !scan_busy_pin_oe && mux_sel == 3'h0)
    else $error("abort did not stop scan");
  scan_end_a: assert property ($fell(scan_busy_pin_oe) |-> mux_sel == 3'h0)
    else $error("scan end input wrong");
  manual_conv_a: assert property (conv_start && !$past(scan_busy_pin_oe) &&
    cfg_out.style == seq_pkg::STYLE_MANUAL && $past(cfg_out.style) == seq_pkg::STYLE_MANUAL
    |-> conv_chan == $past(mux_sel) && mux_sel == $past(mux_sel))
    else $error("manual frame moved input");
  scan_step_a: assert property (conv_start && $past(scan_busy_pin_oe) &&
    scan_busy_pin_oe |-> conv_chan == $past(mux_sel) &&
    (mux_sel > conv_chan || cfg_out.rpt_en))
    else $error("scan step wrong");
  pulse_once_a: assert property (conv_start |=> !conv_start)
    else $error("conv pulse too long");
  otf_zero_a: assert property ($rose(otf_error) |->
    mux_sel == 3'h0 && conv_chan == 3'h0)
    else $error("bad code input not zero");
endmodule

bind adc_mux_channel_sequencer seq_properties #(.NUM_CH(NUM_CH), .REC_DEPTH(REC_DEPTH))
  u_seq_properties (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .scan_launch_bit(scan_launch_bit),
  .scan_cancel_bit(scan_cancel_bit), .cfg_out(cfg_out), .mux_sel(mux_sel),
  .conv_start(conv_start), .conv_chan(conv_chan), .otf_error(otf_error),
  .scan_busy_pin_o(scan_busy_pin_o), .scan_busy_pin_oe(scan_busy_pin_oe));

/* File: test/spi_host_model.sv */
// Serial host model sending frames to the sequencer.
// Assumes the sequencer oversamples the pins with its own clock.
`timescale 1ns/10ps
module spi_host_model (
  output logic sclk, // Serial clock
  output logic cs_n, // Chip select
  output logic sdi // Serial data
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Bits go MSB first from word[23]; clock idles low
  task automatic send(input logic [23:0] word, input int n);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = word[23-i];
      #160 sclk = 1'b1;
      #160 sclk = 1'b0;
    end
    #160 cs_n = 1'b1;
    sdi = ~sdi;
    #400;
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the channel sequencer.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr, scan_launch_bit, scan_cancel_bit, flag_clear, rec_ready, hold;
  logic sclk, cs_n, sdi, conv_start, otf_error, rec_drop, busy_o, busy_oe, rec_valid;
  logic [2:0] mux_sel, conv_chan, c;
  logic [5:0] e;
  seq_pkg::cfg_s cfg_in, cfg_out;
  seq_pkg::conv_rec_s rec_data;
  logic [5:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  always #20 clk = ~clk;
  spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  adc_mux_channel_sequencer u_adc_mux_channel_sequencer (.clk(clk), .rst(rst),
    .sclk_pin(sclk), .cs_n_pin(cs_n), .sdi_pin(sdi), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .scan_launch_bit(scan_launch_bit), .scan_cancel_bit(scan_cancel_bit),
    .flag_clear(flag_clear), .cfg_out(cfg_out), .mux_sel(mux_sel), .conv_start(conv_start),
    .conv_chan(conv_chan), .otf_error(otf_error), .rec_drop(rec_drop),
    .scan_busy_pin_o(busy_o), .scan_busy_pin_oe(busy_oe), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_data(rec_data));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] ex);
    compares++;
    if (seen !== ex) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, ex, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk) #1 s = 1'b1;
    @(posedge clk) #1 s = 1'b0;
  endtask
  task automatic set_cfg(input logic [1:0] st, input logic o, r, input logic [7:0] mk);
    cfg_in = '{st, o, r, mk};
    pulse(cfg_wr);
    check("cfg_out", cfg_out, cfg_in);
  endtask
  // Expected conv input and new input, then the frame
  task automatic frame(input logic [23:0] w, input int n, input logic [2:0] cv, m);
    exp_q.push_back({cv, m});
    u_host.send(w, n);
  endtask
  function automatic logic [2:0] nxt(input logic [7:0] mk, input logic [2:0] cur);
    nxt = cur;
    for (int k = 8; k >= 1; k--) begin
      if (mk[3'(cur + k)]) nxt = 3'(cur + k);
    end
  endfunction
  always @(posedge clk) begin
    #1;
    rec_ready = hold ? 1'b0 : 1'($urandom_range(0, 1));
  end
  always @(negedge clk) begin
    if (conv_start === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 6'h3F;
      check("conv_chan mux_sel", {conv_chan, mux_sel}, e);
    end
  end
  initial begin
    #2ms;
    failures++;
    print_verdict();
  end
  initial begin
    int n;
    logic [7:0] mk;
    {cfg_wr, scan_launch_bit, scan_cancel_bit, flag_clear, hold} = 5'h00;
    cfg_in = seq_pkg::CFG_RESET;
    void'($urandom(32'h2D31919B));
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    check("cfg_out", cfg_out, seq_pkg::CFG_RESET);
    check("busy", {busy_o, busy_oe, mux_sel}, 5'h00);
    pulse(scan_launch_bit);
    check("busy oe", busy_oe, 1'b0);
    $display("test reset done");
    hold = 1'b1;
    for (int i = 0; i < 10; i++) begin
      frame(24'h000000, 24, 3'h0, 3'h0);
      check("rec_drop", rec_drop, 16'(i == 9));
    end
    hold = 1'b0;
    n = 0;
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      if (rec_valid === 1'b1 && rec_ready === 1'b1) n++;
    end
    check("records", 16'(n), 16'h0009);
    check("rec bits", rec_data.bits, seq_pkg::BITCNT_MAX);
    pulse(flag_clear);
    check("rec_drop", rec_drop, 1'b0);
    $display("test buffer done");
    set_cfg(seq_pkg::STYLE_OTF, 1'b0, 1'b0, 8'hFF);
    hold = 1'b1;
    frame(24'hAFFFFF, 16, 3'h0, 3'h0);
    check("rec head", rec_data.head, 16'hAFFF);
    check("rec bits cmd chan", {rec_data.bits, rec_data.cmd_valid, rec_data.chan},
      {seq_pkg::BITCNT_HEAD, 1'b1, 3'h0});
    hold = 1'b0;
    set_cfg(seq_pkg::STYLE_OTF, 1'b1, 1'b0, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      c = (i < 8) ? 3'(i) : 3'h0;
      frame({1'b1, 4'(i), 19'($urandom)}, 16, c, c);
      check("otf_error", otf_error, 16'(i >= 8));
    end
    frame({1'b1, 4'h5, 19'($urandom)}, 16, 3'h5, 3'h5);
    frame(24'h000000, 16, 3'h5, 3'h5);
    frame({1'b0, 23'($urandom)}, 16, 3'h5, 3'h5);
    pulse(flag_clear);
    check("otf_error", otf_error, 1'b0);
    $display("test fly-by done");
    set_cfg(seq_pkg::STYLE_AUTO, 1'b0, 1'b0, 8'h44);
    pulse(scan_launch_bit);
    check("busy mux", {busy_o, busy_oe, mux_sel}, 5'h1A);
    frame(24'h000000, 16, 3'h2, 3'h6);
    frame(24'h000000, 16, 3'h6, 3'h0);
    check("busy oe", busy_oe, 1'b0);
    frame(24'h000000, 16, 3'h0, 3'h0);
    mk = 8'($urandom_range(1, 255));
    set_cfg(seq_pkg::STYLE_AUTO, 1'b0, 1'b1, mk);
    pulse(scan_launch_bit);
    c = nxt(mk, 3'h7);
    check("mux_sel", mux_sel, c);
    for (int i = 0; i < 10; i++) begin
      frame(24'h000000, 16, c, nxt(mk, c));
      c = nxt(mk, c);
    end
    pulse(scan_cancel_bit);
    check("busy mux", {busy_oe, mux_sel}, 4'h0);
    $display("test scan done");
    check("pending", 16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule
